// file: test/psram_host_chk.sv
// Purpose: Pin checks for the memory host controller.
// Assumes: ce is held high, so each clock counts.
// Notes: Bound to the top module by name.
`timescale 1ns/100ps
`default_nettype none
module psram_host_chk #(
  parameter int INIT_CYCLES = 20
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Memory pins.
  input wire psram_host_pkg::mem_pins_t mem_pins
);
  logic [7:0] low_cnt;
  logic [15:0] up_cnt;
  wire cs_n = mem_pins.chip_select_n;
  wire we_n = mem_pins.write_enable_n;
  wire rd_on = !mem_pins.output_enable_n && we_n;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Select-low run length and age since reset; the age saturates, the run length clears on select high but wraps after 256 low cycles.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      low_cnt <= 8'h00;
      up_cnt <= 16'h0000;
    end
    else
    begin
      low_cnt <= cs_n ? 8'h00 : low_cnt + 8'h01;
      up_cnt <= (up_cnt == 16'hFFFF) ? up_cnt : up_cnt + 16'h0001;
    end
  end
  property p_read_sel; rd_on |-> !cs_n; endproperty
  a_read_sel: assert property (p_read_sel) else $error("read enable without select");
  property p_read_hiz; rd_on |-> !mem_pins.dq_oe; endproperty
  a_read_hiz: assert property (p_read_hiz) else $error("host drives during read");
  property p_wr_drive; !cs_n && !we_n && mem_pins.sleep_n |-> mem_pins.dq_oe; endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("write without data");
  property p_hold; $rose(we_n) && $past(mem_pins.dq_oe) |-> mem_pins.dq_oe && $stable(mem_pins.dq_out); endproperty
  a_hold: assert property (p_hold) else $error("write data not held");
  property p_pulse; $fell(we_n) && mem_pins.sleep_n |-> !we_n [*4] ##1 we_n; endproperty
  a_pulse: assert property (p_pulse) else $error("write pulse length");
  property p_sel_max; !cs_n |-> low_cnt < psram_host_pkg::MAX_SELECT_LOW_CYCLES; endproperty
  a_sel_max: assert property (p_sel_max) else $error("select low too long");
  property p_load_hiz; !mem_pins.sleep_n && !we_n |-> !mem_pins.dq_oe; endproperty
  a_load_hiz: assert property (p_load_hiz) else $error("data driven in pin load");
  property p_init; up_cnt < INIT_CYCLES |-> cs_n; endproperty
  a_init: assert property (p_init) else $error("select during power-up");
endmodule // psram_host_chk
bind psram_host psram_host_chk #(.INIT_CYCLES(INIT_CYCLES)) chk_u (.hclk(hclk), .hresetn(hresetn), .mem_pins(mem_pins));
`default_nettype wire

// file: test/psram_host_test.sv
// Purpose: Self-checking bench for the memory host controller.
// Assumes: Power-up wait shortened to 20 cycles; ce held high.
// Notes: Registers over AHB-Lite; the memory is a behavioural model.
`timescale 1ns/100ps
`default_nettype none
module psram_host_test;
  logic hclk = 1'b0;
  logic hresetn;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic [15:0] mdq;
  psram_host_pkg::mem_pins_t pins;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  // The data wire carries whichever side drives it.
  wire [15:0] dq_in = pins.dq_oe ? pins.dq_out : mdq;
  psram_host #(.INIT_CYCLES(20)) dut_u (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .mem_pins(pins), .dq_in(dq_in));
  psram_model mem_u (.p(pins), .dq(mdq));
  // Clock, and a cycle ceiling so a hang still ends the run.
  always #12.5 hclk = ~hclk;
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      complete_run;
    end
  end
  task automatic complete_run;
    if (n_fail == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // One single transfer; the data phase waits for ready like the address phase.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0000_0000, q);
  endtask
  task automatic cmd(input logic [2:0] c);
    logic [31:0] s;
    wr(8'h00, {29'h0000_0000, c});
    s = 32'h0000_0001;
    while (s[0] !== 1'b0) rd(8'h10, s);
  endtask
  task automatic mw(input logic [18:0] a, input logic [17:0] d);
    wr(8'h04, {13'h0000, a});
    wr(8'h08, {14'h0000, d});
    cmd(3'h1);
  endtask
  task automatic mr(input logic [18:0] a, input logic [1:0] l, output logic [31:0] q);
    wr(8'h04, {13'h0000, a});
    wr(8'h08, {14'h0000, l, 16'h0000});
    cmd(3'h0);
    rd(8'h0C, q);
  endtask
  task automatic t_reset;
    logic [31:0] q;
    rd(8'h14, q);
    chk("cfg value", 32'h0000_0070, q);
    rd(8'h18, q);
    chk("cfg shadow", 32'h0000_0070, q);
    rd(8'h1C, q);
    chk("unmapped", 32'h0000_0000, q);
  endtask
  task automatic t_lanes;
    logic [31:0] q;
    mw(19'h0_0005, 18'h3_1234);
    mw(19'h0_0005, 18'h2_AB00);
    mr(19'h0_0005, 2'h3, q);
    chk("masked write", 32'h0000_AB34, q);
    mr(19'h0_0005, 2'h1, q);
    chk("lower lane", 32'h0000_0034, q);
  endtask
  task automatic t_swcfg;
    logic [31:0] q;
    mw(19'h7_FFFF, 18'h3_5A5A);
    wr(8'h14, 32'h0000_00E0);
    cmd(3'h3);
    cmd(3'h4);
    rd(8'h18, q);
    chk("sw read", 32'h0000_00F0, q);
    mr(19'h7_FFFF, 2'h3, q);
    chk("top word", 32'h0000_5A5A, q);
  endtask
  task automatic t_page;
    logic [31:0] q;
    mw(19'h0_0010, 18'h3_1111);
    mw(19'h0_0011, 18'h3_2222);
    mr(19'h0_0010, 2'h3, q);
    chk("page first", 32'h0000_1111, q);
    mr(19'h0_0011, 2'h3, q);
    chk("page hit", 32'h0000_2222, q);
    rd(8'h10, q);
    chk("page open", 32'h0000_0001, {31'h0000_0000, q[4]});
  endtask
  task automatic t_sleep;
    logic [31:0] q;
    wr(8'h14, 32'h0000_0060);
    cmd(3'h2);
    rd(8'h18, q);
    chk("pin load", 32'h0000_0060, q);
    mw(19'h0_0009, 18'h3_1357);
    cmd(3'h5);
    rd(8'h10, q);
    chk("asleep", 32'h0000_0001, {31'h0000_0000, q[2]});
    cmd(3'h6);
    mr(19'h0_0009, 2'h3, q);
    chk("data lost", 32'h0000_0000, q);
  endtask
  // Main sequence.
  initial
  begin
    hresetn = 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_lanes;
    t_swcfg;
    t_page;
    t_sleep;
    complete_run;
  end
endmodule // psram_host_test
`default_nettype wire

// file: test/psram_model.sv
// Purpose: Behavioural pseudo-static memory at the host pins.
// Assumes: Pins come from host flops with no wire delay.
// Notes: Unwritten or lost words read zero; released lanes show the inverted word.
`timescale 1ns/100ps
`default_nettype none
module psram_model #(
  parameter int ACC_NS = 60,
  parameter int PAGE_NS = 20
) (
  // Pins from the host.
  input wire psram_host_pkg::mem_pins_t p,
  // Data back to the host.
  output logic [15:0] dq
);
  logic [15:0] mem [logic [18:0]];
  logic [18:0] cfg = 19'h0_0070;
  logic [1:0] seq = 2'h0;
  logic wrote = 1'b0;
  logic sw = 1'b0;
  logic [15:0] w;
  realtime t0 = 0.0;
  realtime tk = 0.0;
  logic [15:0] key = 16'h0000;
  wire top = p.addr == 19'h7_FFFF;
  wire wr = !p.chip_select_n && !p.write_enable_n;
  wire rd = !p.chip_select_n && !p.output_enable_n && p.write_enable_n && p.sleep_n;
  // A read as the fourth access of a software sequence returns the configuration.
  always @(p or seq or cfg)
    w = seq == 2'h3 ? cfg[15:0] : mem.exists(p.addr) ? mem[p.addr] : 16'h0000;
  // Disabled lanes float; the inverted word keeps a stale value from passing as data.
  wire [15:0] v = {rd && !p.upper_byte_enable_n ? w[15:8] : ~w[15:8],
    rd && !p.lower_byte_enable_n ? w[7:0] : ~w[7:0]};
  // Inside an open page only the low address bits move, so data follows within the page time.
  always @(v or p)
  begin
    if ({p.chip_select_n, p.addr[18:4]} != key)
      tk = $realtime;
    key = {p.chip_select_n, p.addr[18:4]};
    dq <= #(cfg[7] && !p.chip_select_n && $realtime > tk ? PAGE_NS : ACC_NS) v;
  end
  // Data is taken as select or write enable rises, whichever is first.
  always @(negedge wr)
    if ($realtime > 0.0)
    begin
      wrote = 1'b1;
      if (!p.sleep_n)
        cfg = p.addr;
      else if (!(top && seq[1]))
        mem[p.addr] = {p.upper_byte_enable_n ? w[15:8] : p.dq_out[15:8],
          p.lower_byte_enable_n ? w[7:0] : p.dq_out[7:0]};
      else if (seq[0])
      begin
        cfg[15:0] = p.dq_out;
        sw = 1'b1;
      end
    end
  // Each select rise ends one access of a possible sequence.
  always @(posedge p.chip_select_n)
  begin
    #1; // Lets a write that ends on this same edge be stored first.
    if (top === 1'b1 && seq != 2'h3 && wrote == seq[1])
      seq = seq + 2'h1;
    else
      seq = 2'h0;
    wrote = 1'b0;
  end
  // A short sleep pulse only loads; a long one may drop the array.
  always @(negedge p.sleep_n)
    t0 = $realtime;
  always @(posedge p.sleep_n)
    if ($realtime - t0 > 10000.0 && (!cfg[4] || (!sw && cfg[2:0] == 3'h4)))
      mem.delete();
endmodule // psram_model
`default_nettype wire

// file: verilog/pin_sync3.sv
// Purpose: Three-stage synchroniser for a bus of pin inputs.
// Assumes: Each bit is sampled on hclk; a change counts once stages two and three agree.
// Notes: The first stage feeds only the second stage.
`default_nettype none
`timescale 1ns/100ps
module pin_sync3 #(
  parameter int WIDTH = 16
) (
  // Clock, reset and enable.
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // Raw and filtered data.
  input wire logic [WIDTH-1:0] raw,
  output logic [WIDTH-1:0] synced
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } sync_state_t;
  sync_state_t r;
  sync_state_t next_r;
  logic [WIDTH-1:0] agree;
  // Each bit follows stage three only where stages two and three match.
  always_comb
  begin
    next_r = r;
    agree = ~(r.s2 ^ r.s3);
    next_r.s1 = raw;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    next_r.q = (r.q & ~agree) | (r.s3 & agree);
  end
  // State register, frozen while the enable is low.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      r <= '0;
    else if (ce)
      r <= next_r;
  end
  assign synced = r.q;
endmodule // pin_sync3
`default_nettype wire

// file: verilog/psram_host.sv
// Purpose: Host controller that drives an asynchronous page-mode pseudo-static memory from AHB-Lite registers.
// Assumes: One 40 MHz clock; memory data pins return through a three-stage synchroniser.
// Notes: Software queues one command at a time; the slave answers with no wait states.
`default_nettype none
`timescale 1ns/100ps
module psram_host #(
  parameter int INIT_CYCLES = psram_host_pkg::INIT_CYCLES
) (
  // Clock, reset and enable.
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave port.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Memory pins.
  output psram_host_pkg::mem_pins_t mem_pins,
  input wire logic [15:0] dq_in
);
  localparam int TW = psram_host_pkg::TIMER_W;
  localparam int SW = psram_host_pkg::SEL_CNT_W;

  typedef enum logic [3:0] {
    ST_POWERUP, ST_INIT_WAIT, ST_IDLE, ST_ZZ_FALL, ST_SETUP, ST_WAIT, ST_GAP,
    ST_PAGE_OPEN, ST_SLEEP_WAIT, ST_ASLEEP
  } fsm_t;

  typedef struct packed {
    fsm_t st;
    logic [2:0] pend_cmd;
    logic cmd_pend;
    logic [2:0] act_cmd;
    logic [1:0] step;
    logic more;
    logic [18:0] addr_reg;
    logic [15:0] wdata_reg;
    logic [1:0] lanes;
    logic [15:0] rdata;
    logic [18:0] cfg_value;
    logic [18:0] cfg_shadow;
    logic sw_cfg_used;
    logic ready;
    logic asleep;
    logic refused;
    logic page_open;
    logic [14:0] page_tag;
    logic [SW-1:0] sel_cnt;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic hreadyout;
    logic [31:0] hrdata;
    psram_host_pkg::mem_pins_t pins;
  } host_state_t;

  host_state_t r;
  host_state_t next_r;
  logic tmr_load;
  logic [TW-1:0] tmr_value;
  logic tmr_done;
  logic [15:0] dq_sync;
  logic busy;
  logic seq_we;
  logic seq_last;
  logic seq_drive;
  logic [18:0] seq_addr;
  logic [15:0] seq_data;
  logic [1:0] seq_lanes;
  logic [15:0] sw_word;
  logic page_hit;
  logic [31:0] rd_word;

  // Data pins come from outside the clock domain.
  pin_sync3 #(.WIDTH(psram_host_pkg::DATA_W)) u_dq_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .raw(dq_in),
    .synced(dq_sync)
  );

  // One timer serves access, sleep entry and initialisation waits.
  wait_timer #(.WIDTH(TW)) u_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .load(tmr_load),
    .value(tmr_value),
    .done(tmr_done)
  );

  // Describe the access for the active command and step.
  always_comb
  begin
    // Reserved bits zero and the sleep bit forced so software never selects deep power-down.
    sw_word = r.cfg_value[15:0] | 16'h0010;
    seq_we = 1'b0;
    seq_last = 1'b1;
    seq_drive = 1'b0;
    seq_addr = r.addr_reg;
    seq_data = r.wdata_reg;
    seq_lanes = r.lanes;
    case (r.act_cmd)
      psram_host_pkg::CMD_WRITE:
      begin
        seq_we = 1'b1;
        seq_drive = 1'b1;
      end
      psram_host_pkg::CMD_CFG_PIN:
      begin
        seq_we = 1'b1;
        seq_addr = r.cfg_value;
        seq_lanes = 2'h3;
      end
      psram_host_pkg::CMD_CFG_SW_WRITE, psram_host_pkg::CMD_CFG_SW_READ:
      begin
        seq_addr = psram_host_pkg::SW_ACCESS_ADDR;
        seq_lanes = 2'h3;
        seq_data = sw_word;
        seq_we = (r.step == 2'd2) || (r.step == 2'd3 && r.act_cmd == psram_host_pkg::CMD_CFG_SW_WRITE);
        seq_drive = seq_we;
        seq_last = (r.step == 2'd3);
      end
      default:
      begin
        seq_we = 1'b0;
      end
    endcase
  end

  // Register read mux; unmapped offsets read as zero.
  always_comb
  begin
    busy = r.cmd_pend || !(r.st == ST_IDLE || r.st == ST_PAGE_OPEN || r.st == ST_ASLEEP);
    page_hit = r.page_open && (r.addr_reg[18:psram_host_pkg::PAGE_LSB] == r.page_tag);
    case (haddr[7:0])
      psram_host_pkg::REG_CMD: rd_word = {29'h0, r.pend_cmd};
      psram_host_pkg::REG_ADDR: rd_word = {13'h0, r.addr_reg};
      psram_host_pkg::REG_WDATA: rd_word = {14'h0, r.lanes, r.wdata_reg};
      psram_host_pkg::REG_RDATA: rd_word = {16'h0, r.rdata};
      psram_host_pkg::REG_STATUS: rd_word = {26'h0, r.refused, r.page_open, r.sw_cfg_used, r.asleep, r.ready, busy};
      psram_host_pkg::REG_CFG_VALUE: rd_word = {13'h0, r.cfg_value};
      psram_host_pkg::REG_CFG_SHADOW: rd_word = {13'h0, r.cfg_shadow};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Bus slave and command sequencer.
  always_comb
  begin
    next_r = r;
    tmr_load = 1'b0;
    tmr_value = '0;
    next_r.hreadyout = 1'b1;
    // Address phase: reads answer in the following data phase.
    next_r.wr_pend = 1'b0;
    if (hsel && hready && htrans[1])
    begin
      next_r.wr_pend = hwrite;
      next_r.wr_addr = haddr[7:0];
      next_r.hrdata = hwrite ? 32'h0000_0000 : rd_word;
    end
    // Data phase of a write.
    if (r.wr_pend)
    begin
      case (r.wr_addr)
        psram_host_pkg::REG_CMD:
        begin
          if (r.cmd_pend)
            next_r.refused = 1'b1;
          else
          begin
            next_r.pend_cmd = hwdata[2:0];
            next_r.cmd_pend = 1'b1;
          end
        end
        psram_host_pkg::REG_ADDR: next_r.addr_reg = hwdata[18:0];
        psram_host_pkg::REG_WDATA:
        begin
          next_r.wdata_reg = hwdata[15:0];
          next_r.lanes = hwdata[17:16];
        end
        psram_host_pkg::REG_CFG_VALUE: next_r.cfg_value = hwdata[18:0] & psram_host_pkg::CFG_WRITABLE_MASK;
        default: next_r.wr_addr = r.wr_addr;
      endcase
    end
    // Track how long select has been low.
    if (r.pins.chip_select_n)
      next_r.sel_cnt = '0;
    else if (r.sel_cnt != '1)
      next_r.sel_cnt = r.sel_cnt + SW'(1);
    case (r.st)
      ST_POWERUP:
      begin
        tmr_load = 1'b1;
        tmr_value = TW'(INIT_CYCLES);
        next_r.st = ST_INIT_WAIT;
      end
      ST_INIT_WAIT:
      begin
        // Select stays high until the memory has initialised.
        next_r.pins.chip_select_n = 1'b1;
        if (tmr_done)
        begin
          next_r.ready = 1'b1;
          next_r.st = ST_IDLE;
        end
      end
      ST_IDLE:
      begin
        // Select and sleep both high: the memory sits in standby.
        if (r.cmd_pend)
        begin
          next_r.cmd_pend = 1'b0;
          next_r.act_cmd = r.pend_cmd;
          next_r.step = 2'd0;
          // A fresh accepted command clears the refusal flag unless a register write is in its data phase now.
          next_r.refused = next_r.refused && r.wr_pend;
          case (r.pend_cmd)
            psram_host_pkg::CMD_READ, psram_host_pkg::CMD_WRITE,
            psram_host_pkg::CMD_CFG_SW_WRITE, psram_host_pkg::CMD_CFG_SW_READ:
              next_r.st = ST_SETUP;
            psram_host_pkg::CMD_CFG_PIN:
            begin
              next_r.pins.sleep_n = 1'b0;
              next_r.st = ST_ZZ_FALL;
            end
            psram_host_pkg::CMD_SLEEP:
            begin
              next_r.pins.sleep_n = 1'b0;
              tmr_load = 1'b1;
              tmr_value = TW'(psram_host_pkg::SLEEP_ENTRY_CYCLES);
              next_r.st = ST_SLEEP_WAIT;
            end
            default: next_r.refused = 1'b1;
          endcase
        end
      end
      ST_ZZ_FALL:
        next_r.st = ST_SETUP;
      ST_SETUP:
      begin
        // Drive address, lanes and strobes; output enable stays high for writes.
        next_r.pins.addr = seq_addr;
        next_r.pins.chip_select_n = 1'b0;
        next_r.pins.write_enable_n = !seq_we;
        next_r.pins.output_enable_n = seq_we;
        next_r.pins.lower_byte_enable_n = !seq_lanes[0];
        next_r.pins.upper_byte_enable_n = !seq_lanes[1];
        next_r.pins.dq_out = seq_data;
        next_r.pins.dq_oe = seq_drive;
        next_r.more = !seq_last;
        tmr_load = 1'b1;
        if (seq_we)
          tmr_value = TW'(psram_host_pkg::WRITE_CYCLES);
        else if (page_hit && r.act_cmd == psram_host_pkg::CMD_READ)
          tmr_value = TW'(psram_host_pkg::PAGE_CYCLES + psram_host_pkg::SYNC_CYCLES);
        else
          tmr_value = TW'(psram_host_pkg::ACCESS_CYCLES + psram_host_pkg::SYNC_CYCLES);
        next_r.page_open = 1'b0;
        next_r.st = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (tmr_done)
        begin
          if (!seq_we)
          begin
            // Disabled lanes are masked, so they read back as zero whatever the pins show.
            next_r.rdata = dq_sync & {{8{seq_lanes[1]}}, {8{seq_lanes[0]}}};
            if (seq_last && r.act_cmd == psram_host_pkg::CMD_CFG_SW_READ)
              next_r.cfg_shadow = {3'h0, dq_sync};
          end
          if (seq_last && r.act_cmd == psram_host_pkg::CMD_CFG_SW_WRITE)
          begin
            next_r.cfg_shadow = {3'h0, sw_word};
            next_r.sw_cfg_used = 1'b1;
          end
          if (seq_last && r.act_cmd == psram_host_pkg::CMD_CFG_PIN)
            next_r.cfg_shadow = r.cfg_value;
          // Page reads keep select and output enable low while the page stays open.
          if (!seq_we && seq_last && r.act_cmd == psram_host_pkg::CMD_READ &&
              r.cfg_shadow[psram_host_pkg::CFG_PAGE_BIT])
          begin
            next_r.page_open = 1'b1;
            next_r.page_tag = r.addr_reg[18:psram_host_pkg::PAGE_LSB];
            next_r.st = ST_PAGE_OPEN;
          end
          else
          begin
            // Select and write enable rise together while data is still driven.
            next_r.pins.chip_select_n = 1'b1;
            next_r.pins.write_enable_n = 1'b1;
            next_r.pins.output_enable_n = 1'b1;
            next_r.step = r.step + 2'd1;
            next_r.st = ST_GAP;
          end
        end
      end
      ST_GAP:
      begin
        // Data released one cycle after the strobes rose, giving hold time.
        next_r.pins.dq_oe = 1'b0;
        next_r.pins.lower_byte_enable_n = 1'b1;
        next_r.pins.upper_byte_enable_n = 1'b1;
        // Sleep rises long before the entry time, so a load never enters low power.
        next_r.pins.sleep_n = 1'b1;
        next_r.st = r.more ? ST_SETUP : ST_IDLE;
      end
      ST_PAGE_OPEN:
      begin
        if (r.sel_cnt >= SW'(psram_host_pkg::PAGE_CLOSE_CYCLES) ||
            (r.cmd_pend && !(r.pend_cmd == psram_host_pkg::CMD_READ &&
             r.addr_reg[18:psram_host_pkg::PAGE_LSB] == r.page_tag)))
        begin
          // Close before the select-low limit; any other command reopens from idle.
          next_r.pins.chip_select_n = 1'b1;
          next_r.pins.output_enable_n = 1'b1;
          next_r.page_open = 1'b0;
          next_r.more = 1'b0;
          next_r.st = ST_GAP;
        end
        else if (r.cmd_pend)
        begin
          next_r.cmd_pend = 1'b0;
          next_r.act_cmd = r.pend_cmd;
          next_r.step = 2'd0;
          next_r.st = ST_SETUP;
        end
      end
      ST_SLEEP_WAIT:
      begin
        if (tmr_done)
        begin
          next_r.asleep = 1'b1;
          next_r.st = ST_ASLEEP;
        end
      end
      ST_ASLEEP:
      begin
        if (r.cmd_pend)
        begin
          next_r.cmd_pend = 1'b0;
          if (r.pend_cmd == psram_host_pkg::CMD_WAKE)
          begin
            next_r.pins.sleep_n = 1'b1;
            next_r.asleep = 1'b0;
            if (!r.cfg_shadow[psram_host_pkg::CFG_SLEEP_BIT])
            begin
              // Leaving deep power-down needs a full initialisation wait.
              next_r.ready = 1'b0;
              tmr_load = 1'b1;
              tmr_value = TW'(INIT_CYCLES);
              next_r.st = ST_INIT_WAIT;
            end
            else
              next_r.st = ST_IDLE;
          end
          else
            next_r.refused = 1'b1;
        end
      end
      default:
        next_r.st = ST_IDLE;
    endcase
  end

  // State register, frozen while the enable is low.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      r <= '0;
      r.st <= ST_POWERUP;
      r.lanes <= psram_host_pkg::LANES_RESET;
      r.cfg_value <= psram_host_pkg::CFG_RESET;
      r.cfg_shadow <= psram_host_pkg::CFG_RESET;
      r.hreadyout <= 1'b1;
      r.pins <= psram_host_pkg::PINS_IDLE;
    end
    else if (ce)
      r <= next_r;
  end

  // Outputs straight from the state register.
  assign hreadyout = r.hreadyout;
  assign hresp = 1'b0 & r.hreadyout;
  assign hrdata = r.hrdata;
  assign mem_pins = r.pins;
endmodule // psram_host
`default_nettype wire

// file: verilog/psram_host_pkg.sv
// Purpose: Shared constants and carrier types for the pseudo-static memory host controller.
// Assumes: A 40 MHz hclk; times are in nanoseconds and turned into cycle counts here.
// Notes: Register offsets are byte addresses on the AHB-Lite slave port.
`default_nettype none
package psram_host_pkg;
  // Clock and memory timing, every time in nanoseconds.
  localparam int CLK_PERIOD_NS = 25;
  localparam int ADDRESS_ACCESS_TIME_NS = 70;
  localparam int PAGE_ACCESS_TIME_NS = 25;
  localparam int WRITE_PULSE_NS = 70;
  localparam int MAX_SELECT_LOW_TIME_NS = 4000;
  localparam int SLEEP_ENTRY_NS = 10000;
  localparam int INIT_TIME_NS = 150000;
  // Cycle counts: least times round up, longest times round down.
  localparam int ACCESS_CYCLES = (ADDRESS_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PAGE_CYCLES = (PAGE_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_CYCLES = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MAX_SELECT_LOW_CYCLES = MAX_SELECT_LOW_TIME_NS / CLK_PERIOD_NS;
  // Sleep must be held strictly longer than the entry time.
  localparam int SLEEP_ENTRY_CYCLES = (SLEEP_ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Three synchroniser stages plus the agreement stage.
  localparam int SYNC_CYCLES = 4;
  // Margin kept below the select-low limit before an open page is closed.
  localparam int PAGE_CLOSE_CYCLES = MAX_SELECT_LOW_CYCLES - ACCESS_CYCLES - SYNC_CYCLES - 2;
  localparam int TIMER_W = 13;
  localparam int SEL_CNT_W = 8;
  // Memory geometry.
  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;
  localparam int PAGE_LSB = 4;
  localparam logic [18:0] SW_ACCESS_ADDR = 19'h7_FFFF;
  // Configuration word layout.
  localparam logic [18:0] CFG_RESET = 19'h0_0070;
  localparam logic [18:0] CFG_WRITABLE_MASK = 19'h0_00F7;
  localparam int CFG_SLEEP_BIT = 4;
  localparam int CFG_PAGE_BIT = 7;
  // Register byte offsets.
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_CFG_VALUE = 8'h14;
  localparam logic [7:0] REG_CFG_SHADOW = 8'h18;
  localparam logic [1:0] LANES_RESET = 2'h3;
  // Command codes written to the command register.
  localparam logic [2:0] CMD_READ = 3'h0;
  localparam logic [2:0] CMD_WRITE = 3'h1;
  localparam logic [2:0] CMD_CFG_PIN = 3'h2;
  localparam logic [2:0] CMD_CFG_SW_WRITE = 3'h3;
  localparam logic [2:0] CMD_CFG_SW_READ = 3'h4;
  localparam logic [2:0] CMD_SLEEP = 3'h5;
  localparam logic [2:0] CMD_WAKE = 3'h6;
  // Status bit positions.
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_READY_BIT = 1;
  localparam int ST_ASLEEP_BIT = 2;
  localparam int ST_SW_CFG_BIT = 3;
  localparam int ST_PAGE_BIT = 4;
  localparam int ST_REFUSED_BIT = 5;
  // Pins driven towards the memory, all flip-flop outputs.
  typedef struct packed {
    logic [18:0] addr;
    logic [15:0] dq_out;
    logic dq_oe;
    logic chip_select_n;
    logic output_enable_n;
    logic write_enable_n;
    logic lower_byte_enable_n;
    logic upper_byte_enable_n;
    logic sleep_n;
  } mem_pins_t;
  localparam mem_pins_t PINS_IDLE = '{addr: 19'h0_0000, dq_out: 16'h0000, dq_oe: 1'b0,
    chip_select_n: 1'b1, output_enable_n: 1'b1, write_enable_n: 1'b1,
    lower_byte_enable_n: 1'b1, upper_byte_enable_n: 1'b1, sleep_n: 1'b1};
endpackage
`default_nettype wire

// file: verilog/wait_timer.sv
// Purpose: Loadable down counter that marks the end of a wait.
// Assumes: A load of N makes done rise after N enabled clock edges.
// Notes: Load must be at least one, otherwise done never drops.
`default_nettype none
`timescale 1ns/100ps
module wait_timer #(
  parameter int WIDTH = 13
) (
  // Clock, reset and enable.
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // Load and completion.
  input wire logic load,
  input wire logic [WIDTH-1:0] value,
  output logic done
);
  typedef struct packed {
    logic [WIDTH-1:0] count;
  } timer_state_t;
  timer_state_t r;
  timer_state_t next_r;
  // Count down to zero and rest there.
  always_comb
  begin
    next_r = r;
    if (load)
      next_r.count = value;
    else if (r.count != '0)
      next_r.count = r.count - WIDTH'(1);
  end
  // State register, frozen while the enable is low.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      r <= '0;
    else if (ce)
      r <= next_r;
  end
  assign done = (r.count == '0);
endmodule // wait_timer
`default_nettype wire
